// >>> inc/mcpm_params.svh
/*
  Constants shared by both ends of the module control link: timing, addresses,
  memory map, host register map and field positions.
  Assumes a 10 MHz system clock on both ends.
*/
`ifndef MCPM_PARAMS_SVH
`define MCPM_PARAMS_SVH

`define MCPM_CLK_HZ 10000000
// Power-on initialisation limit
`define MCPM_INIT_MS 2000
`define MCPM_INIT_CYCLES (`MCPM_INIT_MS * (`MCPM_CLK_HZ / 1000))
// Reset qualification threshold
`define MCPM_RST_MIN_US 10
`define MCPM_RST_QUAL_CYCLES (`MCPM_RST_MIN_US * (`MCPM_CLK_HZ / 1000000))
// Quarter of a serial clock period
`define MCPM_SCL_QTR_CYCLES 25
`define MCPM_DEV_ADDR 7'h50
`define MCPM_NUM_CH 4

// Module memory map
`define MCPM_MM_STATUS 8'h00
`define MCPM_MM_FLAGS 8'h01
`define MCPM_MM_CHAN_OFF 8'h02
`define MCPM_ST_NOT_READY 0
`define MCPM_ST_LOW_POWER 1
`define MCPM_ST_ALERT 2
`define MCPM_FL_RESET_DONE 0
`define MCPM_FL_FAULT_LSB 4

// Host controller registers
`define MCPM_A_CTRL 8'h00
`define MCPM_A_STATUS 8'h04
`define MCPM_A_CMD 8'h08
`define MCPM_A_RDATA 8'h0c
`define MCPM_A_SLAVE 8'h10
`define MCPM_CTRL_SEL 0
`define MCPM_CTRL_RST 1
`define MCPM_CTRL_LP 2
`define MCPM_CTRL_RESET 3'h4
`define MCPM_STS_PRESENT 0
`define MCPM_STS_ALERT 1
`define MCPM_STS_BUSY 2
`define MCPM_STS_NACK 3
`define MCPM_STS_RST_WAIT 4
`define MCPM_CMD_PTR_LSB 0
`define MCPM_CMD_DATA_LSB 8
`define MCPM_CMD_READ 16

`endif

// >>> inc/mcpm_pkg.sv
/*
  Types of the module control link: state encodings of both ends.
  Assumes nothing of its surroundings.
*/
package mcpm_pkg;

  typedef enum logic [6:0] {
    SL_IDLE = 7'b0000001,
    SL_ADDR = 7'b0000010,
    SL_AACK = 7'b0000100,
    SL_WR   = 7'b0001000,
    SL_WACK = 7'b0010000,
    SL_RD   = 7'b0100000,
    SL_RACK = 7'b1000000
  } mcpm_slv_t;

  typedef enum logic [3:0] {
    HS_IDLE  = 4'b0001,
    HS_START = 4'b0010,
    HS_BYTE  = 4'b0100,
    HS_STOP  = 4'b1000
  } mcpm_hop_t;

endpackage

// >>> inc/mcpm_link_if.sv
/*
  Control pins and two-wire bus between host controller and module.
  Open-drain lines are resolved here with pull-ups to high.
*/
`timescale 1ns/1ns
interface mcpm_link_if;
  logic module_select_n;
  logic module_reset_n;
  logic low_power_select;
  logic scl;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic dev_present_out;
  logic dev_present_oe;
  logic dev_alert_out;
  logic dev_alert_oe;
  logic sda;
  logic module_present_n;
  logic fault_alert_n;

  assign sda = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));
  assign module_present_n = !(dev_present_oe && !dev_present_out);
  assign fault_alert_n = !(dev_alert_oe && !dev_alert_out);

  modport host (
    output module_select_n, module_reset_n, low_power_select, scl,
    output host_sda_out, host_sda_oe,
    input sda, module_present_n, fault_alert_n
  );

  modport dev (
    input module_select_n, module_reset_n, low_power_select, scl, sda,
    output dev_sda_out, dev_sda_oe, dev_present_out, dev_present_oe,
    output dev_alert_out, dev_alert_oe
  );
endinterface

// >>> rtl/mcpm_module.sv
/*
  Module end of the control link: pin synchronisers, reset qualification,
  initialisation timer, two-wire bus slave with a small memory map, alert.
  Assumes the host makes the serial clock and pulls up the open-drain lines.
*/
// Added by the designer: the register addresses and register access over APB.
// Operation
// - Serve bus only while select held low
// - Host gives each module its own select
// - Host accesses memory map over SCL/SDA
// - Long reset pulse restores all defaults
// - Host ignores status until reset completes
// - Completion clears not-ready and raises alert
// - Power-up raises completion alert by itself
// - Low-power select limits power consumption
// - Present line pulled low when inserted
// - Alert driven low on fault or status
// - Host reads status to find alert cause
// - Alert is open-drain, host pulls up
// - Functional within 2000 ms of power
// - Channels individually disabled by management
`timescale 1ns/1ns
`include "mcpm_params.svh"
module mcpm_module
  import mcpm_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `MCPM_DEV_ADDR,
  parameter int NUM_CH = `MCPM_NUM_CH,
  parameter int INIT_CYCLES = `MCPM_INIT_CYCLES,
  parameter int RST_QUAL_CYCLES = `MCPM_RST_QUAL_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  mcpm_link_if.dev link,
  input wire logic [NUM_CH-1:0] chan_fault,
  output logic [NUM_CH-1:0] chan_enable,
  output logic power_limit_low,
  output logic module_ready
);

  // Pin order: select, reset, low power, scl, sda
  logic [4:0] pin_raw;
  logic [4:0] p1;
  logic [4:0] p2;
  logic [4:0] p3;
  logic [4:0] ps;
  logic [4:0] ps_q;
  logic [4:0] agree;
  logic sel_n;
  logic rst_pin_n;
  logic scl;
  logic sda;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [31:0] rst_cnt;
  logic soft_rst;
  logic [31:0] init_cnt;
  logic not_ready;
  logic done_evt;
  mcpm_slv_t st;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic [7:0] ptr;
  logic rw;
  logic first;
  logic nack;
  logic sda_oe;
  logic wr_stb;
  logic [7:0] wr_ptr;
  logic [7:0] wr_byte;
  logic rd_flags;
  logic [7:0] rd_byte;
  logic [NUM_CH-1:0] chan_off;
  logic [NUM_CH-1:0] fault_flag;
  logic reset_done;
  logic alert;

  assign pin_raw = {link.module_select_n, link.module_reset_n, link.low_power_select,
                    link.scl, link.sda};
  assign agree = ~(p2 ^ p3);
  assign sel_n = ps[4];
  assign rst_pin_n = ps[3];
  assign scl = ps[1];
  assign sda = ps[0];
  assign scl_q = ps_q[1];
  assign sda_q = ps_q[0];
  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign bus_start = scl & scl_q & sda_q & ~sda;
  assign bus_stop = scl & scl_q & ~sda_q & sda;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      p1 <= 5'h1f;
      p2 <= 5'h1f;
      p3 <= 5'h1f;
      ps <= 5'h1f;
      ps_q <= 5'h1f;
    end else begin
      p1 <= pin_raw;
      p2 <= p1;
      p3 <= p2;
      ps <= (ps & ~agree) | (p2 & agree);
      ps_q <= ps;
    end
  end

  // Reset pin must stay low beyond the threshold to count
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_cnt <= 32'h0;
      soft_rst <= 1'b0;
    end else if (rst_pin_n) begin
      rst_cnt <= 32'h0;
      soft_rst <= 1'b0;
    end else if (rst_cnt == 32'(RST_QUAL_CYCLES)) begin
      soft_rst <= 1'b1;
    end else begin
      rst_cnt <= rst_cnt + 32'h1;
    end
  end

  // Initialisation timer, restarted by power-up and by a qualified reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      init_cnt <= 32'h0;
      not_ready <= 1'b1;
      done_evt <= 1'b0;
    end else if (soft_rst) begin
      init_cnt <= 32'h0;
      not_ready <= 1'b1;
      done_evt <= 1'b0;
    end else begin
      done_evt <= 1'b0;
      if (not_ready) begin
        if (init_cnt == 32'(INIT_CYCLES - 1)) begin
          not_ready <= 1'b0;
          done_evt <= 1'b1;
        end else begin
          init_cnt <= init_cnt + 32'h1;
        end
      end
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (ptr)
      `MCPM_MM_STATUS: begin
        rd_byte[`MCPM_ST_NOT_READY] = not_ready;
        rd_byte[`MCPM_ST_LOW_POWER] = power_limit_low;
        rd_byte[`MCPM_ST_ALERT] = alert;
      end
      `MCPM_MM_FLAGS: begin
        rd_byte[`MCPM_FL_RESET_DONE] = reset_done;
        rd_byte[`MCPM_FL_FAULT_LSB +: NUM_CH] = fault_flag;
      end
      `MCPM_MM_CHAN_OFF: rd_byte[NUM_CH-1:0] = chan_off;
      default: rd_byte = 8'h00;
    endcase
  end

  // Two-wire slave
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= SL_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      txreg <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      first <= 1'b0;
      nack <= 1'b0;
      sda_oe <= 1'b0;
      wr_stb <= 1'b0;
      wr_ptr <= 8'h00;
      wr_byte <= 8'h00;
      rd_flags <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      rd_flags <= 1'b0;
      if (soft_rst || sel_n || bus_stop) begin
        st <= SL_IDLE;
        sda_oe <= 1'b0;
        if (soft_rst) begin
          ptr <= 8'h00;
        end
      end else if (bus_start) begin
        st <= SL_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (st == SL_ADDR || st == SL_WR || st == SL_RD) begin
          shreg <= {shreg[6:0], sda};
          bitcnt <= bitcnt + 4'h1;
        end
        if (st == SL_RACK) begin
          nack <= sda;
        end
      end else if (scl_fall) begin
        unique case (st)
          SL_IDLE: ;
          SL_ADDR: begin
            if (bitcnt == 4'h8) begin
              if (shreg[7:1] == DEV_ADDR) begin
                st <= SL_AACK;
                sda_oe <= 1'b1;
                rw <= shreg[0];
                first <= 1'b1;
              end else begin
                st <= SL_IDLE;
              end
            end
          end
          SL_AACK, SL_RACK: begin
            bitcnt <= 4'h0;
            if ((st == SL_AACK && rw) || (st == SL_RACK && !nack)) begin
              st <= SL_RD;
              sda_oe <= ~rd_byte[7];
              txreg <= {rd_byte[6:0], 1'b0};
              ptr <= ptr + 8'h1;
              rd_flags <= (ptr == `MCPM_MM_FLAGS);
            end else begin
              st <= (st == SL_AACK) ? SL_WR : SL_IDLE;
              sda_oe <= 1'b0;
            end
          end
          SL_WR: begin
            if (bitcnt == 4'h8) begin
              st <= SL_WACK;
              sda_oe <= 1'b1;
              first <= 1'b0;
              if (first) begin
                ptr <= shreg;
              end else begin
                wr_stb <= 1'b1;
                wr_ptr <= ptr;
                wr_byte <= shreg;
                ptr <= ptr + 8'h1;
              end
            end
          end
          SL_WACK: begin
            st <= SL_WR;
            sda_oe <= 1'b0;
            bitcnt <= 4'h0;
          end
          SL_RD: begin
            if (bitcnt == 4'h8) begin
              st <= SL_RACK;
              sda_oe <= 1'b0;
            end else begin
              sda_oe <= ~txreg[7];
              txreg <= {txreg[6:0], 1'b0};
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chan_off <= '0;
    end else if (soft_rst) begin
      chan_off <= '0;
    end else if (wr_stb && wr_ptr == `MCPM_MM_CHAN_OFF) begin
      chan_off <= wr_byte[NUM_CH-1:0];
    end
  end

  // Completion flag: a new event wins over a clearing read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_done <= 1'b0;
    end else if (soft_rst) begin
      reset_done <= 1'b0;
    end else if (done_evt) begin
      reset_done <= 1'b1;
    end else if (rd_flags) begin
      reset_done <= 1'b0;
    end
  end

  for (genvar i = 0; i < NUM_CH; i++) begin : g_chan
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        fault_flag[i] <= 1'b0;
        chan_enable[i] <= 1'b0;
      end else begin
        chan_enable[i] <= ~chan_off[i] & ~not_ready & ~soft_rst;
        if (soft_rst) begin
          fault_flag[i] <= 1'b0;
        end else if (chan_fault[i]) begin
          fault_flag[i] <= 1'b1;
        end else if (rd_flags) begin
          fault_flag[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alert <= 1'b0;
      power_limit_low <= 1'b1;
      module_ready <= 1'b0;
    end else begin
      alert <= reset_done | (|fault_flag);
      power_limit_low <= ps[2];
      module_ready <= ~not_ready;
    end
  end

  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe = sda_oe;
  assign link.dev_alert_out = 1'b0;
  assign link.dev_alert_oe = alert;
  assign link.dev_present_out = 1'b0;
  assign link.dev_present_oe = 1'b1;

endmodule

// >>> rtl/mcpm_host.sv
/*
  Host end of the control link: APB register slave, control pin drivers,
  two-wire bus master for single-byte reads and writes.
  Assumes one module on this link and the pull-ups in the interface.
*/
`timescale 1ns/1ns
`include "mcpm_params.svh"
module mcpm_host
  import mcpm_pkg::*;
#(
  parameter int SCL_QTR = `MCPM_SCL_QTR_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  mcpm_link_if.host link
);

  logic [2:0] p1;
  logic [2:0] p2;
  logic [2:0] p3;
  logic [2:0] ps;
  logic [2:0] agree;
  logic [2:0] ctrl;
  logic [6:0] slv;
  logic [7:0] rdata;
  logic rst_wait;
  logic [15:0] qcnt;
  logic tick;
  mcpm_hop_t hst;
  logic [2:0] step;
  logic [1:0] phase;
  logic [3:0] bitn;
  logic is_read;
  logic [7:0] cmd_ptr;
  logic [7:0] cmd_data;
  logic [7:0] txb;
  logic [7:0] rxb;
  logic nack;
  logic apb_wr;
  logic mapped;
  logic [2:0] next_step;

  assign agree = ~(p2 ^ p3);
  assign apb_wr = psel & penable & pready & pwrite;
  assign mapped = paddr == `MCPM_A_CTRL || paddr == `MCPM_A_STATUS ||
                  paddr == `MCPM_A_CMD || paddr == `MCPM_A_RDATA || paddr == `MCPM_A_SLAVE;
  assign tick = qcnt == 16'(SCL_QTR - 1);
  assign next_step = step + 3'h1;

  function automatic mcpm_hop_t seq_op(input logic [2:0] s, input logic rd);
    if (s == 3'h0 || (rd && s == 3'h3)) begin
      return HS_START;
    end
    if ((!rd && s == 3'h4) || s == 3'h6) begin
      return HS_STOP;
    end
    return HS_BYTE;
  endfunction

  function automatic logic [7:0] seq_byte(input logic [2:0] s);
    case (s)
      3'h1: return {slv, 1'b0};
      3'h2: return cmd_ptr;
      3'h3: return cmd_data;
      3'h4: return {slv, 1'b1};
      default: return 8'hff;
    endcase
  endfunction

  // Pin order: present, alert, sda
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      p1 <= 3'h7;
      p2 <= 3'h7;
      p3 <= 3'h7;
      ps <= 3'h7;
    end else begin
      p1 <= {link.module_present_n, link.fault_alert_n, link.sda};
      p2 <= p1;
      p3 <= p2;
      ps <= (ps & ~agree) | (p2 & agree);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel && !penable) begin
        prdata <= 32'h0;
        case (paddr)
          `MCPM_A_CTRL: prdata[2:0] <= ctrl;
          `MCPM_A_STATUS: begin
            prdata[`MCPM_STS_PRESENT] <= ~ps[2];
            prdata[`MCPM_STS_ALERT] <= ~ps[1];
            prdata[`MCPM_STS_BUSY] <= hst != HS_IDLE;
            prdata[`MCPM_STS_NACK] <= nack;
            prdata[`MCPM_STS_RST_WAIT] <= rst_wait;
          end
          `MCPM_A_RDATA: prdata[7:0] <= rdata;
          `MCPM_A_SLAVE: prdata[6:0] <= slv;
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= `MCPM_CTRL_RESET;
      slv <= `MCPM_DEV_ADDR;
    end else if (apb_wr && paddr == `MCPM_A_CTRL) begin
      ctrl <= pwdata[2:0];
    end else if (apb_wr && paddr == `MCPM_A_SLAVE) begin
      slv <= pwdata[6:0];
    end
  end

  // Status is untrusted from reset request until the completion alert
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_wait <= 1'b1;
    end else if (ctrl[`MCPM_CTRL_RST]) begin
      rst_wait <= 1'b1;
    end else if (!ps[1]) begin
      rst_wait <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link.module_select_n <= 1'b1;
      link.module_reset_n <= 1'b1;
      link.low_power_select <= 1'b1;
    end else begin
      link.module_select_n <= ~ctrl[`MCPM_CTRL_SEL];
      link.module_reset_n <= ~ctrl[`MCPM_CTRL_RST];
      link.low_power_select <= ctrl[`MCPM_CTRL_LP];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      qcnt <= 16'h0;
    end else if (hst == HS_IDLE || tick) begin
      qcnt <= 16'h0;
    end else begin
      qcnt <= qcnt + 16'h1;
    end
  end

  // Two-wire master, four ticks per bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hst <= HS_IDLE;
      step <= 3'h0;
      phase <= 2'h0;
      bitn <= 4'h0;
      is_read <= 1'b0;
      cmd_ptr <= 8'h00;
      cmd_data <= 8'h00;
      txb <= 8'h00;
      rxb <= 8'h00;
      rdata <= 8'h00;
      nack <= 1'b0;
      link.scl <= 1'b1;
      link.host_sda_oe <= 1'b0;
    end else if (hst == HS_IDLE) begin
      if (apb_wr && paddr == `MCPM_A_CMD) begin
        hst <= HS_START;
        step <= 3'h0;
        phase <= 2'h0;
        nack <= 1'b0;
        is_read <= pwdata[`MCPM_CMD_READ];
        cmd_ptr <= pwdata[`MCPM_CMD_PTR_LSB +: 8];
        cmd_data <= pwdata[`MCPM_CMD_DATA_LSB +: 8];
      end
    end else if (tick) begin
      phase <= phase + 2'h1;
      if (phase == 2'h1) begin
        link.scl <= 1'b1;
      end
      unique case (hst)
        HS_START: begin
          if (phase == 2'h0) link.host_sda_oe <= 1'b0;
          if (phase == 2'h2) link.host_sda_oe <= 1'b1;
        end
        HS_BYTE: begin
          if (phase == 2'h0) link.host_sda_oe <= (bitn != 4'h8) & ~txb[7];
          if (phase == 2'h2 && bitn != 4'h8) rxb <= {rxb[6:0], ps[0]};
          if (phase == 2'h2 && bitn == 4'h8 && ps[0] && !(is_read && step == 3'h5)) begin
            nack <= 1'b1;
          end
        end
        HS_STOP: begin
          if (phase == 2'h0) link.host_sda_oe <= 1'b1;
          if (phase == 2'h2) link.host_sda_oe <= 1'b0;
        end
        HS_IDLE: ;
      endcase
      if (phase == 2'h3) begin
        if (hst != HS_STOP) link.scl <= 1'b0;
        txb <= {txb[6:0], 1'b1};
        if (hst == HS_BYTE && bitn != 4'h8) begin
          bitn <= bitn + 4'h1;
        end else if (hst == HS_STOP) begin
          hst <= HS_IDLE;
          if (is_read && !nack) rdata <= rxb;
        end else if (nack) begin
          hst <= HS_STOP;
          step <= 3'h6;
        end else begin
          bitn <= 4'h0;
          step <= next_step;
          hst <= seq_op(next_step, is_read);
          txb <= seq_byte(next_step);
        end
      end
    end
  end

  assign link.host_sda_out = 1'b0;

endmodule

// >>> verif/mcpm_chk.sv
/*
  Checker of the module control link: select gating, open-drain lines,
  serial clock shape, power-up and module reset completion alerts.
  Assumes one clock and the shortened counts handed on by the bench.
*/
`timescale 1ns/1ns
module mcpm_chk #(
  parameter int INIT_CYCLES = 200,
  parameter int RST_QUAL_CYCLES = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic scl,
  input wire logic host_sda_out,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic dev_alert_out,
  input wire logic dev_present_oe,
  input wire logic module_present_n,
  input wire logic fault_alert_n
);
  localparam int WMAX = INIT_CYCLES + 30;
  logic [31:0] up_cnt;
  logic [31:0] low_cnt;

  // Cycles since power-up, saturating
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      up_cnt <= 32'h0;
    end else if (up_cnt < INIT_CYCLES + 16) begin
      up_cnt <= up_cnt + 32'h1;
    end
  end

  // Length of the current low on the module reset pin
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt <= 32'h0;
    end else if (module_reset_n) begin
      low_cnt <= 32'h0;
    end else begin
      low_cnt <= low_cnt + 32'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_deselected;
    module_select_n [*8];
  endsequence
  sequence s_long_rst;
    $rose(module_reset_n) && low_cnt > RST_QUAL_CYCLES + 2;
  endsequence
  sequence s_short_rst;
    $rose(module_reset_n) && low_cnt < RST_QUAL_CYCLES && fault_alert_n;
  endsequence

  property p_sel_gate;
    s_deselected |-> !dev_sda_oe;
  endproperty
  property p_sda_od;
    !dev_sda_out && !host_sda_out;
  endproperty
  property p_sda_edge;
    $changed(dev_sda_oe) |-> !scl;
  endproperty
  property p_scl_high;
    $rose(scl) |=> scl [*3];
  endproperty
  property p_present;
    dev_present_oe && !module_present_n;
  endproperty
  property p_alert_od;
    !dev_alert_out;
  endproperty
  property p_init_quiet;
    up_cnt < INIT_CYCLES |-> fault_alert_n;
  endproperty
  property p_init_alert;
    up_cnt == INIT_CYCLES + 8 |-> !fault_alert_n;
  endproperty
  property p_long_rst;
    s_long_rst |-> ##[1:WMAX] !fault_alert_n;
  endproperty
  property p_short_rst;
    s_short_rst |-> fault_alert_n [*8];
  endproperty

  a_sel_gate: assert property (p_sel_gate) else $error("sda driven while deselected");
  a_sda_od: assert property (p_sda_od) else $error("sda driven high");
  a_sda_edge: assert property (p_sda_edge) else $error("sda moved with scl high");
  a_scl_high: assert property (p_scl_high) else $error("scl high too short");
  a_present: assert property (p_present) else $error("present line not low");
  a_alert_od: assert property (p_alert_od) else $error("alert driven high");
  a_init_quiet: assert property (p_init_quiet) else $error("alert before init");
  a_init_alert: assert property (p_init_alert) else $error("no power-up alert");
  a_long_rst: assert property (p_long_rst) else $error("no alert after reset");
  a_short_rst: assert property (p_short_rst) else $error("short reset acted");
endmodule

// >>> verif/mcpm_tb.sv
/*
  Testbench joining host and module ends over the link interface.
  Assumes shortened init, reset and serial clock counts.
*/
`timescale 1ns/1ns
`include "mcpm_params.svh"
module mcpm_tb;
  localparam int INIT = 200;
  localparam int RQ = 8;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] chan_fault = 4'h0;
  logic [3:0] chan_enable;
  logic power_limit_low;
  logic module_ready;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int num_checks = 0;

  always #50 clk = ~clk;

  mcpm_link_if link();
  mcpm_module #(.INIT_CYCLES(INIT), .RST_QUAL_CYCLES(RQ)) u_mcpm_module (.clk(clk),
    .reset_n(reset_n), .link(link), .chan_fault(chan_fault), .chan_enable(chan_enable),
    .power_limit_low(power_limit_low), .module_ready(module_ready));
  mcpm_host #(.SCL_QTR(4)) u_mcpm_host (.clk(clk), .reset_n(reset_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  mcpm_chk #(.INIT_CYCLES(INIT), .RST_QUAL_CYCLES(RQ)) u_mcpm_chk (.clk(clk),
    .reset_n(reset_n), .module_select_n(link.module_select_n),
    .module_reset_n(link.module_reset_n), .scl(link.scl), .host_sda_out(link.host_sda_out),
    .dev_sda_out(link.dev_sda_out), .dev_sda_oe(link.dev_sda_oe),
    .dev_alert_out(link.dev_alert_out), .dev_present_oe(link.dev_present_oe),
    .module_present_n(link.module_present_n), .fault_alert_n(link.fault_alert_n));

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic timeout();
    miscompares++;
    $display("Wait limit ran out at %0t", $time);
    print_verdict();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) timeout();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // One serial bus byte access, then fetch the read byte
  task automatic cmd(input logic rdn, input logic [7:0] ptr, input logic [7:0] dat);
    int n;
    apb(1'b1, `MCPM_A_CMD, {15'h0, rdn, dat, ptr});
    n = 0;
    do begin
      apb(1'b0, `MCPM_A_STATUS, 32'h0);
      n++;
    end while (rd[`MCPM_STS_BUSY] !== 1'b0 && n < 1000);
    if (rd[`MCPM_STS_BUSY] !== 1'b0) timeout();
    apb(1'b0, `MCPM_A_RDATA, 32'h0);
  endtask

  task automatic wait_alert(input int lim);
    int n;
    n = 0;
    while (link.fault_alert_n !== 1'b0 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (link.fault_alert_n !== 1'b0) timeout();
  endtask

  task automatic t_power_up();
    wait_alert(INIT + 50);
    chk(32'(module_ready), 32'h1);
    chk(32'(power_limit_low), 32'h1);
    apb(1'b1, `MCPM_A_CTRL, 32'h5);
    cmd(1'b1, `MCPM_MM_FLAGS, 8'h0);
    chk(rd, 32'h1);
    chk(32'(link.fault_alert_n), 32'h1);
    cmd(1'b1, `MCPM_MM_STATUS, 8'h0);
    chk(rd, 32'h2);
    apb(1'b0, `MCPM_A_STATUS, 32'h0);
    chk(rd, 32'h1);
  endtask

  task automatic t_low_power();
    apb(1'b1, `MCPM_A_CTRL, 32'h1);
    repeat (8) @(posedge clk);
    chk(32'(power_limit_low), 32'h0);
    cmd(1'b1, `MCPM_MM_STATUS, 8'h0);
    chk(rd, 32'h0);
  endtask

  task automatic t_channels();
    cmd(1'b0, `MCPM_MM_CHAN_OFF, 8'h05);
    chk(32'(chan_enable), 32'ha);
    cmd(1'b1, `MCPM_MM_CHAN_OFF, 8'h0);
    chk(rd, 32'h5);
  endtask

  task automatic t_fault();
    chan_fault <= 4'h4;
    @(posedge clk);
    chan_fault <= 4'h0;
    wait_alert(20);
    cmd(1'b1, `MCPM_MM_FLAGS, 8'h0);
    chk(rd, 32'h40);
    chk(32'(link.fault_alert_n), 32'h1);
  endtask

  task automatic t_short_reset();
    apb(1'b1, `MCPM_A_CTRL, 32'h3);
    apb(1'b1, `MCPM_A_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    chk(32'(link.fault_alert_n), 32'h1);
    cmd(1'b1, `MCPM_MM_CHAN_OFF, 8'h0);
    chk(rd, 32'h5);
  endtask

  task automatic t_long_reset();
    apb(1'b1, `MCPM_A_CTRL, 32'h3);
    repeat (30) @(posedge clk);
    apb(1'b1, `MCPM_A_CTRL, 32'h1);
    chk(32'(module_ready), 32'h0);
    chk(32'(chan_enable), 32'h0);
    apb(1'b0, `MCPM_A_STATUS, 32'h0);
    chk(rd, 32'h11);
    wait_alert(INIT + 50);
    cmd(1'b1, `MCPM_MM_FLAGS, 8'h0);
    chk(rd, 32'h1);
    cmd(1'b1, `MCPM_MM_CHAN_OFF, 8'h0);
    chk(rd, 32'h0);
  endtask

  task automatic t_deselect();
    apb(1'b1, `MCPM_A_CTRL, 32'h0);
    cmd(1'b1, `MCPM_MM_STATUS, 8'h0);
    apb(1'b0, `MCPM_A_STATUS, 32'h0);
    chk(rd, 32'h9);
    apb(1'b0, 8'h14, 32'h0);
    chk(32'(err), 32'h1);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_power_up();
    t_low_power();
    t_channels();
    t_fault();
    t_short_reset();
    t_long_reset();
    t_deselect();
    print_verdict();
  end
endmodule
